// [common/secondary_timer_cfg.svh]
`ifndef SECONDARY_TIMER_CFG_SVH
`define SECONDARY_TIMER_CFG_SVH

// Register byte addresses on the register bus.
`define ADDR_CONTROL_ZERO     16'he8ac
`define ADDR_COMMAND          16'he8b0
`define ADDR_SYNC_CONFIG      16'he8b4
`define ADDR_COMPARE_ACTIVE   16'he8b8
`define ADDR_COMPARE_SHADOW   16'he8bc
`define ADDR_PERIOD           16'he8c0
`define ADDR_COUNTER          16'he8c4
`define ADDR_STATUS           16'he8c8

// Control register zero fields.
`define CTRL_DIR_BIT          6
`define CTRL_ALIGN_BIT        7
`define CTRL_CLKSEL_LSB       8
`define CTRL_CLKSEL_MSB       10
`define CTRL_PRESCALE_BIT     11
`define CTRL_RUN_BIT          12
`define CTRL_SHADOW_REQ_BIT   13

// Command register fields, write-only, read as zero.
`define CMD_RUN_SET_BIT       0
`define CMD_RUN_CLEAR_BIT     1
`define CMD_SHADOW_SET_BIT    2
`define CMD_SHADOW_CLEAR_BIT  3
`define CMD_COUNT_RESET_BIT   4
`define CMD_STATE_SET_BIT     5
`define CMD_STATE_CLEAR_BIT   6

// Synchronisation and output configuration fields.
`define SYNC_SINGLE_SHOT_BIT  1
`define SYNC_TRIG_LSB         2
`define SYNC_TRIG_MSB         4
`define SYNC_TDIR_LSB         5
`define SYNC_TDIR_MSB         6
`define SYNC_PIN_POL_BIT      8
`define SYNC_MOD_POL_BIT      9

// Status register fields.
`define STATUS_STATE_BIT      0
`define STATUS_MATCH_BIT      1

// Reset values.
`define RESET_WORD16          16'h0000

// Extra prescaler adds a factor of 1/256, an exponent of eight.
`define PRESCALE_EXTRA_EXP    4'h8

`endif

// [common/secondary_timer_pkg.sv]
package secondary_timer_pkg;

  typedef enum logic [2:0] {
    trig_none      = 3'h0,
    trig_cmp0      = 3'h1,
    trig_cmp1      = 3'h2,
    trig_cmp2      = 3'h3,
    trig_cmp_any   = 3'h4,
    trig_period    = 3'h5,
    trig_zero_up   = 3'h6,
    trig_hall      = 3'h7
  } trigger_select_type;

  typedef enum logic [1:0] {
    tdir_reserved  = 2'h0,
    tdir_up        = 2'h1,
    tdir_down      = 2'h2,
    tdir_any       = 2'h3
  } trigger_direction_type;

  typedef enum logic [1:0] {
    resp_okay      = 2'h0,
    resp_slverr    = 2'h2
  } axi_resp_type;

endpackage : secondary_timer_pkg

// [core/secondary_prescaler.sv]
`timescale 1ns/10ps
`default_nettype none

module secondary_prescaler
  import secondary_timer_pkg::*;
#(
  parameter int WIDTH = 15
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_run,
  input  wire logic [2:0] i_clock_select,
  input  wire logic       i_extra_prescale,
  output logic            o_tick
);
`include "secondary_timer_cfg.svh"

  logic [WIDTH-1:0] count_r;
  logic [3:0]       exp_w;
  logic [WIDTH-1:0] mask_w;

  // Divide by two to the power of the select field, times 256 when enabled.
  assign exp_w  = {1'b0, i_clock_select} +
                  (i_extra_prescale ? `PRESCALE_EXTRA_EXP : 4'h0);
  assign mask_w = WIDTH'((32'h1 << exp_w) - 32'h1);
  assign o_tick = i_run & ((count_r & mask_w) == mask_w);

  // Held at zero while stopped, so the first tick after a start always
  // comes one full division later.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_r <= '0;
    end else if (!i_run) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + WIDTH'(1);
    end
  end

endmodule : secondary_prescaler

`default_nettype wire

// [core/secondary_timer_compare_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module secondary_timer_compare_sync
  import secondary_timer_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 15
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [15:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [15:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic [2:0]  i_primary_compare,
  input  wire logic        i_primary_period_match,
  input  wire logic        i_primary_zero_match,
  input  wire logic        i_primary_count_direction,
  input  wire logic        i_hall_state_change,
  output logic             o_secondary_pwm_line,
  output logic             o_internal_modulation_line,
  output logic             o_channel_match,
  output logic             o_secondary_zero_match,
  output logic             o_secondary_shadow_pulse,
  output logic             o_single_shot_end,
  output logic             o_secondary_run_flag
);
`include "secondary_timer_cfg.svh"

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  function automatic logic addr_is(input logic [15:0] addr,
                                   input logic [15:0] reg_addr);
    addr_is = (addr[15:2] == reg_addr[15:2]);
  endfunction : addr_is

  function automatic logic pick_event(input trigger_select_type sel,
                                      input logic [2:0] cmp,
                                      input logic per,
                                      input logic zero,
                                      input logic down,
                                      input logic hall);
    unique case (sel)
      trig_none:    pick_event = 1'b0;
      trig_cmp0:    pick_event = cmp[0];
      trig_cmp1:    pick_event = cmp[1];
      trig_cmp2:    pick_event = cmp[2];
      trig_cmp_any: pick_event = |cmp;
      trig_period:  pick_event = per;
      trig_zero_up: pick_event = zero & ~down;
      trig_hall:    pick_event = hall;
    endcase
  endfunction : pick_event

  function automatic logic dir_allows(input trigger_direction_type tdir,
                                      input logic down);
    unique case (tdir)
      tdir_reserved: dir_allows = 1'b0;
      tdir_up:       dir_allows = ~down;
      tdir_down:     dir_allows = down;
      tdir_any:      dir_allows = 1'b1;
    endcase
  endfunction : dir_allows

  // Register bus state.
  logic                  aw_held_r;
  logic [15:0]           awaddr_r;
  logic                  w_held_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  bvalid_r;
  axi_resp_type          bresp_r;
  logic                  rvalid_r;
  logic [31:0]           rdata_r;
  axi_resp_type          rresp_r;
  logic [31:0]           rdata_nxt;
  logic                  rmapped_nxt;
  logic                  do_write;
  logic                  wmapped;

  // Timer state.
  logic                  run_r;
  logic                  shadow_req_r;
  logic                  extra_prescale_r;
  logic [2:0]            clock_select_r;
  logic                  align_mode_r;
  logic                  single_shot_r;
  trigger_select_type    trig_sel_r;
  trigger_direction_type trig_dir_r;
  logic                  pin_pol_r;
  logic                  mod_pol_r;
  logic [15:0]           count_r;
  logic [15:0]           period_r;
  logic [15:0]           period_shadow_r;
  logic [15:0]           compare_r;
  logic [15:0]           compare_shadow_r;
  logic                  state_r;
  logic                  pwm_line_r;
  logic                  mod_line_r;

  logic tick;
  logic period_hit;
  logic zero_match;
  logic channel_match;
  logic shadow_pulse;
  logic trigger;
  logic run_set;
  logic run_clear;
  logic cmd_run_set;
  logic cmd_run_clear;
  logic cmd_shadow_set;
  logic cmd_shadow_clear;
  logic cmd_count_reset;
  logic cmd_state_set;
  logic cmd_state_clear;
  logic wr_ctrl;
  logic wr_sync;
  logic wr_cmp_shadow;
  logic wr_period;
  logic wr_count;

  assign o_awready = ~aw_held_r & ~bvalid_r;
  assign o_wready  = ~w_held_r & ~bvalid_r;
  assign o_arready = ~rvalid_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;

  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign wmapped  = addr_is(awaddr_r, `ADDR_CONTROL_ZERO) |
                    addr_is(awaddr_r, `ADDR_COMMAND) |
                    addr_is(awaddr_r, `ADDR_SYNC_CONFIG) |
                    addr_is(awaddr_r, `ADDR_COMPARE_ACTIVE) |
                    addr_is(awaddr_r, `ADDR_COMPARE_SHADOW) |
                    addr_is(awaddr_r, `ADDR_PERIOD) |
                    addr_is(awaddr_r, `ADDR_COUNTER) |
                    addr_is(awaddr_r, `ADDR_STATUS);

  assign wr_ctrl       = do_write & addr_is(awaddr_r, `ADDR_CONTROL_ZERO);
  assign wr_sync       = do_write & addr_is(awaddr_r, `ADDR_SYNC_CONFIG);
  assign wr_cmp_shadow = do_write & addr_is(awaddr_r, `ADDR_COMPARE_SHADOW);
  assign wr_period     = do_write & addr_is(awaddr_r, `ADDR_PERIOD);
  assign wr_count      = do_write & addr_is(awaddr_r, `ADDR_COUNTER);

  // Command bits are one-cycle strobes taken from byte lane zero.
  logic cmd_lane;
  assign cmd_lane = do_write & addr_is(awaddr_r, `ADDR_COMMAND) & wstrb_r[0];
  assign cmd_run_set      = cmd_lane & wdata_r[`CMD_RUN_SET_BIT];
  assign cmd_run_clear    = cmd_lane & wdata_r[`CMD_RUN_CLEAR_BIT];
  assign cmd_shadow_set   = cmd_lane & wdata_r[`CMD_SHADOW_SET_BIT];
  assign cmd_shadow_clear = cmd_lane & wdata_r[`CMD_SHADOW_CLEAR_BIT];
  assign cmd_count_reset  = cmd_lane & wdata_r[`CMD_COUNT_RESET_BIT];
  assign cmd_state_set    = cmd_lane & wdata_r[`CMD_STATE_SET_BIT];
  assign cmd_state_clear  = cmd_lane & wdata_r[`CMD_STATE_CLEAR_BIT];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 16'h0000;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= resp_okay;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wmapped ? resp_okay : resp_slverr;
      end else if (bvalid_r && i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_nxt   = 32'h0000_0000;
    rmapped_nxt = 1'b1;
    if (addr_is(i_araddr, `ADDR_CONTROL_ZERO)) begin
      rdata_nxt[`CTRL_SHADOW_REQ_BIT] = shadow_req_r;
      rdata_nxt[`CTRL_RUN_BIT]        = run_r;
      rdata_nxt[`CTRL_PRESCALE_BIT]   = extra_prescale_r;
      rdata_nxt[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB] = clock_select_r;
      rdata_nxt[`CTRL_ALIGN_BIT]      = align_mode_r;
      rdata_nxt[`CTRL_DIR_BIT]        = i_primary_count_direction;
    end else if (addr_is(i_araddr, `ADDR_SYNC_CONFIG)) begin
      rdata_nxt[`SYNC_SINGLE_SHOT_BIT] = single_shot_r;
      rdata_nxt[`SYNC_TRIG_MSB:`SYNC_TRIG_LSB] = trig_sel_r;
      rdata_nxt[`SYNC_TDIR_MSB:`SYNC_TDIR_LSB] = trig_dir_r;
      rdata_nxt[`SYNC_PIN_POL_BIT] = pin_pol_r;
      rdata_nxt[`SYNC_MOD_POL_BIT] = mod_pol_r;
    end else if (addr_is(i_araddr, `ADDR_COMPARE_ACTIVE)) begin
      rdata_nxt[15:0] = compare_r;
    end else if (addr_is(i_araddr, `ADDR_COMPARE_SHADOW)) begin
      rdata_nxt[15:0] = compare_shadow_r;
    end else if (addr_is(i_araddr, `ADDR_PERIOD)) begin
      rdata_nxt[15:0] = period_r;
    end else if (addr_is(i_araddr, `ADDR_COUNTER)) begin
      rdata_nxt[15:0] = count_r;
    end else if (addr_is(i_araddr, `ADDR_STATUS)) begin
      rdata_nxt[`STATUS_STATE_BIT] = state_r;
      rdata_nxt[`STATUS_MATCH_BIT] = channel_match;
    end else if (!addr_is(i_araddr, `ADDR_COMMAND)) begin
      rmapped_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= resp_okay;
    end else if (i_arvalid && o_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rmapped_nxt ? resp_okay : resp_slverr;
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  secondary_prescaler #(
    .WIDTH            (PRESCALE_WIDTH)
  ) u_prescaler (
    .i_clk            (i_clk),
    .i_rstn           (i_rstn),
    .i_run            (run_r),
    .i_clock_select   (clock_select_r),
    .i_extra_prescale (extra_prescale_r),
    .o_tick           (tick)
  );

  assign trigger = pick_event(trig_sel_r, i_primary_compare,
                              i_primary_period_match, i_primary_zero_match,
                              i_primary_count_direction,
                              i_hall_state_change) &
                   dir_allows(trig_dir_r, i_primary_count_direction);

  assign period_hit    = run_r & tick & (count_r == period_r);
  assign zero_match    = (count_r == 16'h0000);
  assign channel_match = (count_r == compare_r);
  assign o_single_shot_end = period_hit & single_shot_r;
  assign shadow_pulse  = shadow_req_r & (period_hit | ~run_r);

  assign run_set   = cmd_run_set | trigger;
  assign run_clear = cmd_run_clear | o_single_shot_end;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_r <= 1'b0;
    end else if (run_set ^ run_clear) begin
      run_r <= run_set;
    end
  end

  // A software request in the same cycle as a transfer stays pending.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shadow_req_r <= 1'b0;
    end else if (cmd_shadow_set) begin
      shadow_req_r <= 1'b1;
    end else if (shadow_pulse || cmd_shadow_clear) begin
      shadow_req_r <= 1'b0;
    end
  end

  // Clock choice changes only while stopped so a period is never stretched.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      extra_prescale_r <= 1'b0;
      clock_select_r   <= 3'h0;
      align_mode_r     <= 1'b0;
    end else if (wr_ctrl) begin
      if (wstrb_r[0]) begin
        align_mode_r <= wdata_r[`CTRL_ALIGN_BIT];
      end
      if (wstrb_r[1] && !run_r) begin
        extra_prescale_r <= wdata_r[`CTRL_PRESCALE_BIT];
        clock_select_r   <= wdata_r[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      single_shot_r <= 1'b0;
      trig_sel_r    <= trig_none;
      trig_dir_r    <= tdir_reserved;
      pin_pol_r     <= 1'b0;
      mod_pol_r     <= 1'b0;
    end else if (wr_sync) begin
      if (wstrb_r[0]) begin
        single_shot_r <= wdata_r[`SYNC_SINGLE_SHOT_BIT];
        trig_sel_r    <= trigger_select_type'(
                           wdata_r[`SYNC_TRIG_MSB:`SYNC_TRIG_LSB]);
        trig_dir_r    <= trigger_direction_type'(
                           wdata_r[`SYNC_TDIR_MSB:`SYNC_TDIR_LSB]);
      end
      if (wstrb_r[1]) begin
        pin_pol_r <= wdata_r[`SYNC_PIN_POL_BIT];
        mod_pol_r <= wdata_r[`SYNC_MOD_POL_BIT];
      end
    end
  end

  // Counter writes from software are ignored while the timer runs.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_r <= `RESET_WORD16;
    end else if (cmd_count_reset) begin
      count_r <= 16'h0000;
    end else if (wr_count && !run_r) begin
      count_r <= merge16(count_r, wdata_r, wstrb_r);
    end else if (run_r && tick) begin
      count_r <= period_hit ? 16'h0000 : count_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      compare_shadow_r <= `RESET_WORD16;
      period_shadow_r  <= `RESET_WORD16;
    end else begin
      if (wr_cmp_shadow) begin
        compare_shadow_r <= merge16(compare_shadow_r, wdata_r, wstrb_r);
      end
      if (wr_period) begin
        period_shadow_r <= merge16(period_shadow_r, wdata_r, wstrb_r);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      compare_r <= `RESET_WORD16;
      period_r  <= `RESET_WORD16;
    end else if (shadow_pulse) begin
      compare_r <= compare_shadow_r;
      period_r  <= period_shadow_r;
    end
  end

  // Hardware set beats a software clear arriving in the same cycle.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= 1'b0;
    end else if (cmd_state_set) begin
      state_r <= 1'b1;
    end else if (run_r && tick && (zero_match || channel_match)) begin
      state_r <= channel_match;
    end else if (cmd_state_clear) begin
      state_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_line_r <= 1'b0;
      mod_line_r <= 1'b0;
    end else begin
      pwm_line_r <= state_r ^ pin_pol_r;
      mod_line_r <= state_r ^ mod_pol_r;
    end
  end

  assign o_secondary_pwm_line       = pwm_line_r;
  assign o_internal_modulation_line = mod_line_r;
  assign o_channel_match            = channel_match;
  assign o_secondary_zero_match     = zero_match;
  assign o_secondary_shadow_pulse   = shadow_pulse;
  assign o_secondary_run_flag       = run_r;

endmodule : secondary_timer_compare_sync

`default_nettype wire

// [testbench/secondary_timer_compare_sync_chk.sv]
`timescale 1ns/10ps
`default_nettype none
`include "secondary_timer_cfg.svh"

module secondary_timer_compare_sync_chk (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_wvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        i_rready,
  input wire logic [15:0] i_araddr,
  input wire logic        i_primary_count_direction,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        o_secondary_pwm_line,
  input wire logic        o_secondary_shadow_pulse,
  input wire logic        o_single_shot_end,
  input wire logic        o_secondary_run_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Four quiet cycles cover the write-to-state-to-line lag of a command.
  sequence s_quiet;
    (!o_secondary_run_flag && !i_wvalid && !o_bvalid) [*4];
  endsequence
  sequence s_ctrl_read;
    i_arvalid && o_arready && i_araddr == `ADDR_CONTROL_ZERO;
  endsequence

  property p_state_hold;
    s_quiet |-> $stable(o_secondary_pwm_line);
  endproperty
  property p_shadow_once;
    o_secondary_shadow_pulse && !o_secondary_run_flag
      |=> !o_secondary_shadow_pulse;
  endproperty
  property p_single_shot;
    o_single_shot_end |=> !o_secondary_run_flag;
  endproperty
  property p_dir_read;
    s_ctrl_read
      |=> o_rdata[`CTRL_DIR_BIT] == $past(i_primary_count_direction);
  endproperty
  property p_b_once;
    o_bvalid && i_bready |=> !o_bvalid;
  endproperty
  property p_r_once;
    o_rvalid && i_rready |=> !o_rvalid;
  endproperty
  property p_ar_block;
    o_rvalid |-> !o_arready;
  endproperty
  property p_aw_block;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty

  a_state_hold: assert property (p_state_hold)
    else $error("pin line moved while stopped");
  a_shadow_once: assert property (p_shadow_once)
    else $error("stopped shadow pulse longer than one cycle");
  a_single_shot: assert property (p_single_shot)
    else $error("run flag kept after single shot end");
  a_dir_read: assert property (p_dir_read)
    else $error("direction bit differs from primary direction");
  a_b_once: assert property (p_b_once)
    else $error("write response kept after bready");
  a_r_once: assert property (p_r_once)
    else $error("read data kept after rready");
  a_ar_block: assert property (p_ar_block)
    else $error("arready high with read pending");
  a_aw_block: assert property (p_aw_block)
    else $error("write readies high with response pending");
endmodule : secondary_timer_compare_sync_chk

bind secondary_timer_compare_sync
  secondary_timer_compare_sync_chk chk_u (.*);
`default_nettype wire

// [testbench/primary_timer_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Each request for event codes 1 to 3 and 5 to 7 gives one single-cycle event strobe; codes 0 and 4 give none.
module primary_timer_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_fire,
  input  wire logic [2:0] i_event,
  input  wire logic       i_down,
  output logic [2:0]      o_compare,
  output logic            o_period,
  output logic            o_zero,
  output logic            o_direction,
  output logic            o_hall
);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_compare   <= 3'h0;
      o_period    <= 1'b0;
      o_zero      <= 1'b0;
      o_hall      <= 1'b0;
      o_direction <= 1'b0;
    end else begin
      o_compare   <= (i_fire && i_event < 3'h4) ? 3'h1 << (i_event - 3'h1)
                                                : 3'h0;
      o_period    <= i_fire && i_event == 3'h5;
      o_zero      <= i_fire && i_event == 3'h6;
      o_hall      <= i_fire && i_event == 3'h7;
      o_direction <= i_down;
    end
  end
endmodule : primary_timer_model
`default_nettype wire

// [testbench/test_secondary_timer_compare_sync.sv]
`timescale 1ns/10ps
`default_nettype none
`include "secondary_timer_cfg.svh"

module test_secondary_timer_compare_sync;
  import secondary_timer_pkg::*;
  localparam logic [15:0] ctl = `ADDR_CONTROL_ZERO, cmd = `ADDR_COMMAND;
  localparam logic [15:0] syn = `ADDR_SYNC_CONFIG, act = `ADDR_COMPARE_ACTIVE;
  localparam logic [15:0] shd = `ADDR_COMPARE_SHADOW, per = `ADDR_PERIOD;
  localparam logic [15:0] sts = `ADDR_STATUS;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, fire = 1'b0;
  logic down = 1'b0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic i_primary_period_match, i_primary_zero_match, i_hall_state_change;
  logic i_primary_count_direction, o_secondary_pwm_line, o_channel_match;
  logic o_internal_modulation_line, o_secondary_zero_match;
  logic o_secondary_shadow_pulse, o_single_shot_end, o_secondary_run_flag;
  logic [15:0] i_awaddr = 16'h0000, i_araddr = 16'h0000;
  logic [31:0] i_wdata = 32'h0, o_rdata, q;
  logic [3:0]  i_wstrb = 4'hf;
  logic [2:0]  i_primary_compare, ev = 3'h0;
  logic [1:0]  o_bresp, o_rresp, rsp;
  int          fails = 0, cmp_count = 0, p, m, c, z;

  secondary_timer_compare_sync #(.PRESCALE_WIDTH(15)) dut_u (.*);
  primary_timer_model model_u (.i_clk, .i_rstn, .i_fire(fire), .i_event(ev),
    .i_down(down), .o_compare(i_primary_compare),
    .o_period(i_primary_period_match), .o_zero(i_primary_zero_match),
    .o_direction(i_primary_count_direction), .o_hall(i_hall_state_change));

  always #12.5 i_clk = ~i_clk;

  task automatic complete_run;
    $display("Mismatches %0d in %0d comparisons", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // Sampled at the falling edge, where values equal the next rise.
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    logic at, wt, rt, bt;
    int   n;
    @(posedge i_clk);
    i_awvalid <= w;
    i_wvalid  <= w;
    i_arvalid <= !w;
    i_awaddr  <= a;
    i_araddr  <= a;
    i_wdata   <= d;
    i_bready  <= w;
    i_rready  <= !w;
    for (n = 0; n < 40; n++) begin
      @(negedge i_clk);
      at  = i_awvalid && o_awready;
      wt  = i_wvalid && o_wready;
      rt  = i_arvalid && o_arready;
      bt  = (o_bvalid && i_bready) || (o_rvalid && i_rready);
      q   = o_rdata;
      rsp = w ? o_bresp : o_rresp;
      @(posedge i_clk);
      if (at) i_awvalid <= 1'b0;
      if (wt) i_wvalid <= 1'b0;
      if (rt) i_arvalid <= 1'b0;
      if (bt) break;
    end
    i_bready <= 1'b0;
    i_rready <= 1'b0;
    if (n == 40) begin
      fails++;
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_hi(input logic shot, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge i_clk);
      if ((shot ? o_single_shot_end : o_channel_match) === 1'b1) break;
    end
    if (n == lim) begin
      fails++;
      complete_run();
    end
  endtask : wait_hi

  task automatic cnt(input int n);
    p = 0;
    m = 0;
    c = 0;
    z = 0;
    repeat (n) begin
      @(negedge i_clk);
      p += int'(o_secondary_pwm_line === 1'b1);
      m += int'(o_internal_modulation_line === 1'b1);
      c += int'(o_channel_match === 1'b1);
      z += int'(o_secondary_zero_match === 1'b1);
    end
  endtask : cnt

  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(ctl);
    chk("control reset", 32'h0, q);
    rd(sts);
    chk("status reset", 32'h2, q);
    rd(16'h0000);
    chk("unmapped resp", 32'(resp_slverr), 32'(rsp));
    for (int s = 0; s < 8; s++) for (int e = 1; e < 8; e++)
      for (int t = 0; t < 8; t++) if (e != 4) begin
        wr(cmd, 32'h2);
        wr(syn, 32'((s << 2) | ((t % 4) << 5)));
        down <= t > 3 && s != 6;
        ev   <= 3'(e);
        fire <= 1'b1;
        @(posedge i_clk);
        fire <= 1'b0;
        repeat (3) @(posedge i_clk);
        rd(ctl);
        c = int'((s == e || (s == 4 && e < 4)) && s != 0 && (t % 4 == 3
             || (t % 4 == 1 && !down) || (t % 4 == 2 && down)));
        chk("trigger run", 32'(c) << 12, q & 32'h1000);
      end
    wr(cmd, 32'h2);
    wr(syn, 32'h0);
    down <= 1'b0;
    wr(cmd, 32'h3);
    rd(ctl);
    chk("run both stopped", 32'h0, q & 32'h1000);
    wr(cmd, 32'h1);
    wr(cmd, 32'h3);
    rd(ctl);
    chk("run both running", 32'h1000, q & 32'h1000);
    wr(cmd, 32'h2);
    wr(cmd, 32'h20);
    rd(sts);
    chk("state set", 32'h1, q & 32'h1);
    wr(cmd, 32'h40);
    rd(sts);
    chk("state clear", 32'h0, q & 32'h1);
    wr(shd, 32'h3);
    wr(per, 32'd99);
    wr(act, 32'h1234);
    rd(act);
    chk("active untouched", 32'h0, q);
    rd(shd);
    chk("shadow readback", 32'h3, q);
    wr(cmd, 32'h4);
    rd(ctl);
    chk("request stopped", 32'h0, q & 32'h2000);
    rd(act);
    chk("active loaded", 32'h3, q);
    wr(syn, 32'h100);
    wr(cmd, 32'h11);
    wr(cmd, 32'h4);
    rd(ctl);
    chk("request running", 32'h3000, q & 32'h3000);
    repeat (100) @(posedge i_clk);
    rd(ctl);
    chk("request served", 32'h0, q & 32'h2000);
    cnt(200);
    chk("pin line high", 32'd6, 32'(p));
    chk("modulation high", 32'd194, 32'(m));
    chk("match cycles", 32'd2, 32'(c));
    chk("zero match cycles", 32'd2, 32'(z));
    wr(shd, 32'h0);
    wr(cmd, 32'h4);
    repeat (210) @(posedge i_clk);
    cnt(200);
    chk("zero with match", 32'd200, 32'(m));
    for (int k = 0; k < 2; k++) begin
      wr(cmd, 32'h2);
      wr(ctl, k ? 32'h0a00 : 32'h0300);
      wr(shd, 32'h5);
      wr(cmd, 32'h14);
      wr(cmd, 32'h1);
      wait_hi(1'b0, 8000);
      c = 0;
      do begin
        c++;
        @(negedge i_clk);
      end while (o_channel_match === 1'b1 && c < 2000);
      chk("tick span", k ? 32'd1024 : 32'd8, 32'(c));
    end
    wr(cmd, 32'h2);
    wr(ctl, 32'h0);
    wr(per, 32'd9);
    wr(cmd, 32'h14);
    wr(syn, 32'h2);
    wr(cmd, 32'h1);
    wait_hi(1'b1, 200);
    repeat (2) @(posedge i_clk);
    rd(ctl);
    chk("single shot stop", 32'h0, q & 32'h1000);
    down <= 1'b1;
    repeat (2) @(posedge i_clk);
    rd(ctl);
    chk("direction bit", 32'h40, q & 32'h40);
    complete_run();
  end
endmodule : test_secondary_timer_compare_sync
`default_nettype wire
